// ---- hw/lamp_pwm_fault_defs.svh ----
// constants of the lamp pwm and half-bridge fault status register slice
// assumes a register access port driven by the serial frame decoder
// Summary of operation
// RULE_01: in 7-bit mode the seventh output duty is (field+1)/128.
// RULE_02: in 7-bit mode the eighth output duty is (field+1)/128.
// RULE_03: the internal pwm drives outputs seven and eight only while internal pwm select is set.
// RULE_04: with high resolution enabled each output takes duty from its own 10-bit register.
// RULE_05: the seventh output pwm runs at 170 Hz with select 0 and 225 Hz with select 1.
// RULE_06: the eighth output pwm runs at 170 Hz with select 0 and 225 Hz with select 1.
// RULE_07: an overcurrent on any of the eight switches sets its flag and turns its output off.
// RULE_08: any overcurrent flag also raises the global supply or overcurrent bit.
// RULE_09: with recovery enabled the tripped output restarts itself after the programmed retry time.
// RULE_10: with recovery disabled the host clears the flag and re-enables the output itself.
// RULE_11: underload is checked only while on and flagged after the filter time of low current.
// RULE_12: any unmasked underload event also sets the global underload bit.
// RULE_13: the bridge one mask keeps its high and low side underloads off the global bit.
// RULE_14: the output underload mask keeps all these underloads off the global bit.
// RULE_15: fault flags read back and clear on read, unused bits read zero.
`ifndef LAMP_PWM_FAULT_DEFS_SVH
`define LAMP_PWM_FAULT_DEFS_SVH
`define ADDR_PWM_PAIR_B 5'h09
`define ADDR_OC_FLAGS 5'h10
`define ADDR_ULD_FLAGS 5'h11
`define PWM_PAIR_B_RESET 16'h0000
`define FLAGS_RESET 16'h0000
`define SEVEN_FSEL_BIT 15
`define SEVEN_DUTY_LSB 8
`define EIGHT_FSEL_BIT 7
`define EIGHT_DUTY_LSB 0
`define CLK_HZ 40000000
`define PWM_FREQ_LO_HZ 170
`define PWM_FREQ_HI_HZ 225
// pwm period split into 1024 steps; period constants are steps of one 1/1024
`define STEP_LO_CYC ((`CLK_HZ) / (`PWM_FREQ_LO_HZ * 1024))
`define STEP_HI_CYC ((`CLK_HZ) / (`PWM_FREQ_HI_HZ * 1024))
`define RETRY_UNIT_US 100
`define RETRY_UNIT_CYC ((`CLK_HZ / 1000000) * `RETRY_UNIT_US)
`define ULD_FILTER_US 2000
`define ULD_FILTER_CYC ((`CLK_HZ / 1000000) * `ULD_FILTER_US)
`endif

// ---- hw/lamp_pwm_fault_pkg.sv ----
// types of the lamp pwm and half-bridge fault status register slice
// assumes nothing beyond the register port
package lamp_pwm_fault_pkg;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [4:0] addr;
        logic [15:0] wdata;
    } reg_req_t;
    typedef struct packed {
        logic       internal_pwm_select;
        logic       high_res_duty_enable;
        logic       oc_recovery_enable;
        logic [3:0] overcurrent_retry_time;
        logic [7:0] output_underload_mask;
        logic       bridge_one_underload_mask;
    } cfg_t;
    typedef enum logic [0:0] {OUT_ON, OUT_TRIPPED} trip_state_t;
endpackage

// ---- hw/lamp_pwm_fault_regs.sv ----
// register slice: pwm pair b, overcurrent and underload flags of outputs one to four
// assumes synchronous fault and current inputs from on-chip comparators
`include "lamp_pwm_fault_defs.svh"
module lamp_pwm_fault_regs #(
    parameter int RETRY_UNIT_CYC = `RETRY_UNIT_CYC,
    parameter int ULD_FILTER_CYC = `ULD_FILTER_CYC
) (
    // clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // register access
    input wire lamp_pwm_fault_pkg::reg_req_t REQ,
    output logic [15:0] RDATA,
    // configuration from other control registers
    input wire lamp_pwm_fault_pkg::cfg_t CFG,
    input wire logic [9:0] DUTY7_HI_RES,
    input wire logic [9:0] DUTY8_HI_RES,
    // external pwm inputs
    input wire logic EXT_PWM7,
    input wire logic EXT_PWM8,
    // half-bridge switches, index 0..7 = hs1 ls1 hs2 ls2 hs3 ls3 hs4 ls4
    input wire logic [7:0] SWITCH_ON_REQ,
    input wire logic [7:0] OVERCURRENT,
    input wire logic [7:0] LOW_CURRENT,
    output logic [7:0] SWITCH_ENABLE,
    // lamp outputs and global status
    output logic SEVENTH_OUTPUT,
    output logic EIGHTH_OUTPUT,
    output logic GLOBAL_SUPPLY_OR_OVERCURRENT_BIT,
    output logic GLOBAL_UNDERLOAD_BIT
);
    import lamp_pwm_fault_pkg::*;

    // flag bit positions in the 16-bit status words
    function automatic logic [15:0] place_flags(input logic [7:0] f);
        place_flags = {f[0], f[1], f[2], f[3], f[4], f[5], 4'h0, f[6], f[7], 4'h0};
    endfunction

    logic [15:0] pwm_pair_b_r;
    logic [7:0] oc_flag_r, uld_flag_r;
    logic [15:0] rdata_r;
    logic [7:0] enable_r;
    logic seventh_output_r, eighth_output_r, glob_oc_r, glob_uld_r;

    // one address compare shared by every register strobe
    function automatic logic addr_is(input logic [4:0] a, input logic [4:0] reg_addr);
        addr_is = a == reg_addr;
    endfunction

    wire wr_pwm = REQ.wr && addr_is(REQ.addr, `ADDR_PWM_PAIR_B);
    wire rd_pwm = REQ.rd && addr_is(REQ.addr, `ADDR_PWM_PAIR_B);
    wire rd_oc = REQ.rd && addr_is(REQ.addr, `ADDR_OC_FLAGS);
    wire rd_uld = REQ.rd && addr_is(REQ.addr, `ADDR_ULD_FLAGS);

    // external pwm pins come from outside the clock domain: two flip-flops first
    logic [1:0] ext_meta_r;
    logic [1:0] ext_sync_r;
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ext_meta_r <= 2'h0;
            ext_sync_r <= 2'h0;
        end else begin
            ext_meta_r <= {EXT_PWM8, EXT_PWM7};
            ext_sync_r <= ext_meta_r;
        end
    end


    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pwm_pair_b_r <= `PWM_PAIR_B_RESET;
        end else if (wr_pwm) begin
            pwm_pair_b_r <= REQ.wdata;
        end
    end

    // pwm generators, one per lamp output
    wire [1:0] fsel = {pwm_pair_b_r[`EIGHT_FSEL_BIT], pwm_pair_b_r[`SEVEN_FSEL_BIT]};
    wire [6:0] duty7 = pwm_pair_b_r[`SEVEN_DUTY_LSB +: 7];
    wire [6:0] duty8 = pwm_pair_b_r[`EIGHT_DUTY_LSB +: 7];
    // 7-bit field scaled to 1024 steps: (n+1)*8 steps on
    wire [10:0] thr7_lo = {1'b0, duty7, 3'h0} + 11'h008; // RULE_01
    wire [10:0] thr8_lo = {1'b0, duty8, 3'h0} + 11'h008; // RULE_02
    // high resolution bypasses the shared 7-bit duty fields; frequency select still comes from the shared register
    wire [10:0] thr7 = CFG.high_res_duty_enable ? {1'b0, DUTY7_HI_RES} : thr7_lo; // RULE_04
    wire [10:0] thr8 = CFG.high_res_duty_enable ? {1'b0, DUTY8_HI_RES} : thr8_lo; // RULE_04
    wire [10:0] thr [2];
    assign thr[0] = thr7;
    assign thr[1] = thr8;
    logic [1:0] pwm_level;
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_pwm
            logic [15:0] pre_r;
            logic [9:0] step_r;
            wire [15:0] pre_top = fsel[g] ?
                                  16'(`STEP_HI_CYC - 1) : // RULE_05 RULE_06
                                  16'(`STEP_LO_CYC - 1);
            always_ff @(posedge CLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    pre_r <= 16'h0000;
                    step_r <= 10'h000;
                end else if (pre_r >= pre_top) begin
                    pre_r <= 16'h0000;
                    step_r <= step_r + 10'h001;
                end else begin
                    pre_r <= pre_r + 16'h0001;
                end
            end
            assign pwm_level[g] = {1'b0, step_r} < thr[g];
        end
    endgenerate

    // internal generator only while selected, otherwise the synchronised pin
    wire seventh_output_nxt = CFG.internal_pwm_select ? pwm_level[0] : ext_sync_r[0]; // RULE_03
    wire eighth_output_nxt = CFG.internal_pwm_select ? pwm_level[1] : ext_sync_r[1]; // RULE_03

    // per-switch overcurrent trip, retry and underload filter
    logic [7:0] uld_event;
    generate
        for (g = 0; g < 8; g++) begin : gen_sw
            trip_state_t st_r;
            logic [31:0] cnt_r;
            logic [31:0] uld_cnt_r;
            // retry time counts in whole units, field value plus one
            wire [31:0] retry_cyc = 32'(CFG.overcurrent_retry_time + 1)
                                    * 32'(RETRY_UNIT_CYC);
            wire on = st_r == OUT_ON && SWITCH_ON_REQ[g];
            // trip only on what the flag also sees, so flag and shutdown agree
            wire trip_hit = OVERCURRENT[g] && SWITCH_ENABLE[g];
            wire retry_done = CFG.oc_recovery_enable && cnt_r + 1 >= retry_cyc;
            wire host_rearm = !CFG.oc_recovery_enable && !oc_flag_r[g] && !SWITCH_ON_REQ[g];
            wire uld_low = on && LOW_CURRENT[g];
            always_ff @(posedge CLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    st_r <= OUT_ON;
                    cnt_r <= 32'h0000_0000;
                end else begin
                    unique case (st_r)
                        OUT_ON: begin
                            cnt_r <= 32'h0000_0000;
                            if (trip_hit) st_r <= OUT_TRIPPED; // RULE_07
                        end
                        OUT_TRIPPED: begin
                            cnt_r <= cnt_r + 32'h0000_0001;
                            // without recovery: flag read clear and the request dropped once
                            if (retry_done) begin
                                st_r <= OUT_ON; // RULE_09
                            end else if (host_rearm) begin
                                st_r <= OUT_ON; // RULE_10
                            end
                        end
                    endcase
                end
            end
            always_ff @(posedge CLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    uld_cnt_r <= 32'h0000_0000;
                end else if (uld_low) begin // RULE_11
                    if (uld_cnt_r < 32'(ULD_FILTER_CYC)) begin
                        uld_cnt_r <= uld_cnt_r + 32'h0000_0001;
                    end
                end else begin
                    uld_cnt_r <= 32'h0000_0000;
                end
            end
            // saturating count gives one event per low-current stretch
            assign uld_event[g] = uld_low && uld_cnt_r == 32'(ULD_FILTER_CYC) - 1; // RULE_11
        end
    endgenerate

    wire [7:0] oc_event = OVERCURRENT & SWITCH_ENABLE;
    // a new event in the read cycle wins over the clear
    wire [7:0] oc_nxt = (rd_oc ? 8'h00 : oc_flag_r) | oc_event; // RULE_07 RULE_15
    wire [7:0] uld_nxt = (rd_uld ? 8'h00 : uld_flag_r) | uld_event; // RULE_15
    // global underload bit honours both masks
    wire [7:0] uld_mask = CFG.output_underload_mask | {6'h00, {2{CFG.bridge_one_underload_mask}}};
    wire [7:0] uld_global_src = uld_nxt & ~uld_mask; // RULE_12 RULE_13 RULE_14
    wire [15:0] oc_word = place_flags(oc_flag_r);
    wire [15:0] uld_word = place_flags(uld_flag_r);
    wire [15:0] rdata_nxt = rd_oc ? oc_word : // RULE_15
                            rd_uld ? uld_word :
                            rd_pwm ? pwm_pair_b_r :
                            16'h0000;
    // gate enable drops at the same edge that sets the flag
    wire [7:0] enable_nxt;
    for (g = 0; g < 8; g++) begin : gen_en
        assign enable_nxt[g] = gen_sw[g].st_r == OUT_ON && !(OVERCURRENT[g] && SWITCH_ENABLE[g])
                               && SWITCH_ON_REQ[g]; // RULE_07
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            oc_flag_r <= 8'h00;
            uld_flag_r <= 8'h00;
            rdata_r <= `FLAGS_RESET;
            enable_r <= 8'h00;
            seventh_output_r <= 1'b0;
            eighth_output_r <= 1'b0;
            glob_oc_r <= 1'b0;
            glob_uld_r <= 1'b0;
        end else begin
            oc_flag_r <= oc_nxt;
            uld_flag_r <= uld_nxt;
            rdata_r <= rdata_nxt;
            enable_r <= enable_nxt;
            seventh_output_r <= seventh_output_nxt;
            eighth_output_r <= eighth_output_nxt;
            glob_oc_r <= |oc_nxt; // RULE_08
            glob_uld_r <= |uld_global_src; // RULE_12
        end
    end

    assign RDATA = rdata_r;
    assign SWITCH_ENABLE = enable_r;
    assign SEVENTH_OUTPUT = seventh_output_r;
    assign EIGHTH_OUTPUT = eighth_output_r;
    assign GLOBAL_SUPPLY_OR_OVERCURRENT_BIT = glob_oc_r;
    assign GLOBAL_UNDERLOAD_BIT = glob_uld_r;
endmodule

// ---- testbench/lamp_pwm_fault_properties.sv ----
// concurrent checks of the lamp pwm and fault register slice
// sees only the top module ports; bound from tb_top
module lamp_pwm_fault_properties (
    // clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // watched ports
    input wire lamp_pwm_fault_pkg::reg_req_t REQ,
    input wire logic [15:0] RDATA,
    input wire lamp_pwm_fault_pkg::cfg_t CFG,
    input wire logic EXT_PWM7,
    input wire logic EXT_PWM8,
    input wire logic [7:0] OVERCURRENT,
    input wire logic [7:0] SWITCH_ENABLE,
    input wire logic SEVENTH_OUTPUT,
    input wire logic EIGHTH_OUTPUT,
    input wire logic GLOBAL_SUPPLY_OR_OVERCURRENT_BIT,
    input wire logic GLOBAL_UNDERLOAD_BIT
);
    import lamp_pwm_fault_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    wire logic [7:0] hit = OVERCURRENT & SWITCH_ENABLE;
    a_oc_trip_off: assert property ((hit != 8'h00) |=> ((SWITCH_ENABLE & $past(hit)) == 8'h00))
        else $error("tripped switch stayed enabled");
    a_oc_global_set: assert property ((hit != 8'h00) |=> GLOBAL_SUPPLY_OR_OVERCURRENT_BIT)
        else $error("global overcurrent bit missing");
    a_oc_global_clear: assert property (REQ.rd && REQ.addr == 5'h10 && OVERCURRENT == 8'h00
        ##1 OVERCURRENT == 8'h00 [*2] |-> !GLOBAL_SUPPLY_OR_OVERCURRENT_BIT)
        else $error("global overcurrent bit stuck after clear");
    a_rd_unmapped: assert property (REQ.rd && !(REQ.addr inside {5'h09, 5'h10, 5'h11})
        |=> RDATA == 16'h0000)
        else $error("unmapped read not zero");
    a_flag_unused: assert property (REQ.rd && REQ.addr[4:1] == 4'h8
        |=> (RDATA & 16'h03CF) == 16'h0000)
        else $error("unused flag bit set");
    // the pins pass a two-stage synchroniser and then the output register
    a_ext_seven: assert property (
        !CFG.internal_pwm_select [*2] |-> SEVENTH_OUTPUT == $past(EXT_PWM7, 3))
        else $error("seventh output not external");
    a_ext_eight: assert property (
        !CFG.internal_pwm_select [*2] |-> EIGHTH_OUTPUT == $past(EXT_PWM8, 3))
        else $error("eighth output not external");
    a_uld_masked: assert property (CFG.output_underload_mask == 8'hFF [*2] |-> !GLOBAL_UNDERLOAD_BIT)
        else $error("masked underload reached global bit");
    c_trip: cover property (hit != 8'h00);
    c_uld: cover property (GLOBAL_UNDERLOAD_BIT);
    c_read_uld: cover property (REQ.rd && REQ.addr == 5'h11);
endmodule

// ---- testbench/host_model.sv ----
// host side model: register reads and writes on the request port
// assumes the shared clock; calls start after reset release
module host_model (
    // clock
    input wire logic CLK,
    // register access
    output lamp_pwm_fault_pkg::reg_req_t REQ,
    input wire logic [15:0] RDATA
);
    import lamp_pwm_fault_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    initial REQ = '0;
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge CLK) REQ <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge CLK) REQ <= '0;
    endtask
    // read data is registered: it stands from the edge that takes the read to the next
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge CLK) REQ <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge CLK) REQ <= '0;
        @(posedge CLK) d = RDATA;
    endtask
endmodule

// ---- testbench/tb_top.sv ----
// self-checking bench of the lamp pwm and fault register slice
// assumes host_model and the properties checker are compiled first
module tb_top;
    import lamp_pwm_fault_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK = 1'b0;
    logic ARST_N = 1'b0;
    reg_req_t req;
    cfg_t cfg = '0;
    logic ext7 = 1'b0;
    logic ext8 = 1'b0;
    logic [9:0] hr7 = '0;
    logic [7:0] on_req = '0;
    logic [7:0] oc = '0;
    logic [7:0] lowc = '0;
    logic [15:0] rdata;
    logic [15:0] d;
    logic [7:0] sw_en;
    logic seventh_output;
    logic eighth_output;
    logic g_oc;
    logic g_uld;
    int error_cnt = 0;
    int compares = 0;
    int n;
    int m;
    always #12.5 CLK = ~CLK;
    host_model u_host (.CLK(CLK), .REQ(req), .RDATA(rdata));
    // short counts keep the retry and filter waits brief
    lamp_pwm_fault_regs #(.RETRY_UNIT_CYC(4), .ULD_FILTER_CYC(8)) u_dut (
        .CLK(CLK), .ARST_N(ARST_N), .REQ(req), .RDATA(rdata), .CFG(cfg),
        .DUTY7_HI_RES(hr7), .DUTY8_HI_RES(hr7), .EXT_PWM7(ext7), .EXT_PWM8(ext8),
        .SWITCH_ON_REQ(on_req), .OVERCURRENT(oc), .LOW_CURRENT(lowc),
        .SWITCH_ENABLE(sw_en), .SEVENTH_OUTPUT(seventh_output), .EIGHTH_OUTPUT(eighth_output),
        .GLOBAL_SUPPLY_OR_OVERCURRENT_BIT(g_oc), .GLOBAL_UNDERLOAD_BIT(g_uld));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
        u_host.rd(a, d);
        chk(d, exp);
    endtask
    task automatic trip(input logic [7:0] m);
        @(posedge CLK) oc <= m;
        @(posedge CLK) oc <= '0;
        @(posedge CLK);
    endtask
    task automatic uld(input logic [7:0] l, input logic g, input logic [15:0] f);
        @(posedge CLK) lowc <= l;
        repeat (12) @(posedge CLK);
        chk(16'(g_uld), 16'(g));
        lowc <= '0;
        rdchk(5'h11, f);
    endtask
    initial begin
        repeat (20000) @(posedge CLK);
        error_cnt++;
        finish_test();
    end
    initial begin
        repeat (20) @(posedge CLK);
        ARST_N <= 1'b1;
        foreach (d[i]) if (i < 3) rdchk(i == 0 ? 5'h09 : 5'h0F + 5'(i), 16'h0000);
        repeat (4) @(posedge CLK) {ext7, ext8} <= {~ext7, ext7};
        @(posedge CLK) {ext7, ext8} <= 2'b01;
        repeat (4) @(posedge CLK);
        chk(16'({seventh_output, eighth_output}), 16'h0001);
        u_host.wr(5'h09, 16'hFFFF);
        rdchk(5'h09, 16'hFFFF);
        u_host.wr(5'h10, 16'hFFFF);
        rdchk(5'h10, 16'h0000);
        rdchk(5'h1F, 16'h0000);
        // full duty must hold the seventh and eighth outputs high without a gap
        cfg.internal_pwm_select <= 1'b1;
        repeat (300) @(posedge CLK);
        n = 0;
        m = 0;
        repeat (2000) @(posedge CLK) begin
            n += (seventh_output !== 1'b1);
            m += (eighth_output !== 1'b1);
        end
        chk(16'(n), 16'h0000);
        chk(16'(m), 16'h0000);
        on_req <= 8'hFF;
        repeat (3) @(posedge CLK);
        trip(8'h01);
        chk(16'(sw_en[0]), 16'h0000);
        chk(16'(g_oc), 16'h0001);
        repeat (20) @(posedge CLK);
        chk(16'(sw_en[0]), 16'h0000);
        rdchk(5'h10, 16'h8000);
        rdchk(5'h10, 16'h0000);
        @(posedge CLK) on_req[0] <= 1'b0;
        @(posedge CLK) on_req[0] <= 1'b1;
        repeat (3) @(posedge CLK);
        chk(16'(sw_en[0]), 16'h0001);
        cfg.oc_recovery_enable <= 1'b1;
        cfg.overcurrent_retry_time <= 4'h2;
        trip(8'h80);
        n = 0;
        while (sw_en[7] !== 1'b1 && n < 40) @(posedge CLK) n++;
        chk(16'(n >= 10 && n <= 14), 16'h0001);
        rdchk(5'h10, 16'h0010);
        on_req <= 8'hF7;
        uld(8'h0C, 1'b1, 16'h2000);
        cfg.bridge_one_underload_mask <= 1'b1;
        uld(8'h02, 1'b0, 16'h4000);
        cfg.output_underload_mask <= 8'hFF;
        uld(8'h40, 1'b0, 16'h0020);
        // second reset: both generators restart at step zero, one-step duty shows the step length
        cfg.high_res_duty_enable <= 1'b1;
        hr7 <= 10'h001;
        ARST_N <= 1'b0;
        repeat (3) @(posedge CLK);
        ARST_N <= 1'b1;
        u_host.wr(5'h09, 16'h8000);
        n = 0;
        m = 0;
        repeat (400) @(posedge CLK) begin
            n += (seventh_output === 1'b1);
            m += (eighth_output === 1'b1);
        end
        chk(16'(n >= 170 && n <= 175), 16'h0001);
        chk(16'(m >= 226 && m <= 231), 16'h0001);
        chk(16'(g_oc), 16'h0000);
        rdchk(5'h10, 16'h0000);
        finish_test();
    end
endmodule
bind lamp_pwm_fault_regs lamp_pwm_fault_properties u_props (.CLK(CLK), .ARST_N(ARST_N),
    .REQ(REQ), .RDATA(RDATA), .CFG(CFG), .EXT_PWM7(EXT_PWM7), .EXT_PWM8(EXT_PWM8),
    .OVERCURRENT(OVERCURRENT), .SWITCH_ENABLE(SWITCH_ENABLE),
    .SEVENTH_OUTPUT(SEVENTH_OUTPUT), .EIGHTH_OUTPUT(EIGHTH_OUTPUT),
    .GLOBAL_SUPPLY_OR_OVERCURRENT_BIT(GLOBAL_SUPPLY_OR_OVERCURRENT_BIT),
    .GLOBAL_UNDERLOAD_BIT(GLOBAL_UNDERLOAD_BIT));
